// ==== mss_pkg.sv ====
// Notes on behaviour
// RULE1: Issue step command before testing advance condition.
// RULE2: Successor starts on next tick after success.
// RULE3: Retest condition every tick until it holds.
// RULE4: Trigger command 45h starts at operand step.
// RULE5: Trigger ignores mode, accel, decel, speed words.
// RULE6: Halt, quit, kill stop further step execution.
// RULE7: Quit or kill zero the current step.
// RULE8: Kill also raises emergency stop.
// RULE9: Host should end chains with code zero.
// RULE10: Advance code zero ends sequence after command.
// RULE11: Status operand 0001 selects move-complete bit.
// RULE12: Empty command issues nothing, still tests condition.
// RULE13: Delay code waits operand milliseconds.
// RULE14: Host may write step table entries directly.
// RULE15: Step is eight words in fixed order.
// RULE16: Link word packs successor and advance code.
// RULE17: Status-set advances when any selected bit set.
// RULE18: Code byte: enhanced, axis, direction, parameter.
// RULE19: New trigger abandons current step next tick.
package mss_pkg;

   // ----------------------------------------
   // Word and table geometry
   // ----------------------------------------
   localparam int WORD_W      = 16;
   localparam int STEP_W      = 8;
   localparam int WORDS_STEP  = 8;
   localparam int WSEL_W      = 3;

   // Word order inside one stored step
   localparam logic [2:0] W_MODE  = 3'h0;
   localparam logic [2:0] W_ACCEL = 3'h1;
   localparam logic [2:0] W_DECEL = 3'h2;
   localparam logic [2:0] W_SPEED = 3'h3;
   localparam logic [2:0] W_OPER  = 3'h4;
   localparam logic [2:0] W_CMD   = 3'h5;
   localparam logic [2:0] W_LINK  = 3'h6;
   localparam logic [2:0] W_LVAL  = 3'h7;

   // Link word halves
   localparam int LNK_NEXT_HI = 15;
   localparam int LNK_NEXT_LO = 8;
   localparam int LNK_TYPE_HI = 7;
   localparam int LNK_TYPE_LO = 0;

   // Enhanced code byte fields
   localparam int ENH_FLAG_BIT = 7;
   localparam int ENH_AXIS_HI  = 6;
   localparam int ENH_AXIS_LO  = 5;
   localparam int ENH_DIR_BIT  = 4;
   localparam int ENH_PAR_HI   = 2;
   localparam int ENH_PAR_LO   = 0;

   // Enhanced monitored parameter codes
   localparam logic [2:0] PAR_TGT_POS = 3'h0;
   localparam logic [2:0] PAR_ACT_POS = 3'h1;
   localparam logic [2:0] PAR_TGT_SPD = 3'h4;
   localparam logic [2:0] PAR_ACT_SPD = 3'h5;
   localparam logic [2:0] PAR_STATUS  = 3'h6;

   // ----------------------------------------
   // Character codes
   // ----------------------------------------
   localparam logic [7:0] CMD_NONE    = 8'h00;
   localparam logic [7:0] CMD_TRIGGER = 8'h45;
   localparam logic [7:0] CMD_HALT    = 8'h48;
   localparam logic [7:0] CMD_QUIT    = 8'h51;
   localparam logic [7:0] CMD_KILL    = 8'h4b;

   localparam logic [7:0] LT_END      = 8'h00;
   localparam logic [7:0] LT_BSET     = 8'h42;
   localparam logic [7:0] LT_BCLR     = 8'h62;
   localparam logic [7:0] LT_DELAY    = 8'h44;
   localparam logic [7:0] LT_LIMIT    = 8'h4c;
   localparam logic [7:0] LT_ACTPOS   = 8'h6c;
   localparam logic [7:0] LT_TSPEED   = 8'h53;
   localparam logic [7:0] LT_ASPEED   = 8'h73;

   localparam logic [15:0] ZERO_W     = 16'h0000;
   localparam logic [7:0]  STEP_RST   = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] tgt_pos;
      logic [15:0] act_pos;
      logic [15:0] tgt_spd;
      logic [15:0] act_spd;
      logic [15:0] status;
   } mss_axis_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] accel;
      logic [15:0] decel;
      logic [15:0] speed;
      logic [15:0] oper;
      logic [15:0] cmd;
   } mss_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ISSUE,
      ST_TEST,
      ST_NEXT
   } mss_state_t;

endpackage

// ==== mss_link_eval.sv ====
`timescale 1ns/1ns
// Advance condition evaluator, purely combinational
module mss_link_eval
   import mss_pkg::*;
(
   input  wire logic [7:0]  i_type,     // Advance code byte
   input  wire logic [15:0] i_value,    // Advance operand
   input  wire mss_axis_t   i_own,      // This axis
   input  wire mss_axis_t   i_other,    // Other axis
   input  wire logic        i_delay_done, // Delay counter expired
   output logic             o_met       // Condition holds
);

   // ----------------------------------------
   // Compare helper
   // ----------------------------------------
   function automatic logic reach(input logic [15:0] a, input logic [15:0] b, input logic gt);
      reach = gt ? (a >= b) : (a <= b);
   endfunction

   mss_axis_t  sel;   // Monitored axis
   logic [2:0] par;   // Monitored parameter
   logic       dir;   // Greater-or-less

   // ----------------------------------------
   // Decode and test
   // ----------------------------------------
   always_comb begin
      sel = i_type[ENH_AXIS_LO] ? i_other : i_own;
      par = i_type[ENH_PAR_HI:ENH_PAR_LO];
      dir = i_type[ENH_DIR_BIT];
      o_met = 1'b0;
      if (i_type[ENH_FLAG_BIT]) begin                          // RULE18
         unique case (par)
            PAR_TGT_POS: o_met = reach(sel.tgt_pos, i_value, dir);
            PAR_ACT_POS: o_met = reach(sel.act_pos, i_value, dir);
            PAR_TGT_SPD: o_met = reach(sel.tgt_spd, i_value, dir);
            PAR_ACT_SPD: o_met = reach(sel.act_spd, i_value, dir);
            PAR_STATUS:  o_met = |(sel.status & i_value);
            default:     o_met = 1'b0;                         // Reserved codes
         endcase
      end else begin
         unique case (i_type)
            LT_BSET:   o_met = |(i_own.status & i_value);      // RULE11 RULE17
            LT_BCLR:   o_met = |(~i_own.status & i_value);
            LT_DELAY:  o_met = i_delay_done;                    // RULE13
            LT_LIMIT:  o_met = reach(i_own.tgt_pos, i_value, 1'b1);
            LT_ACTPOS: o_met = reach(i_own.act_pos, i_value, 1'b1);
            LT_TSPEED: o_met = reach(i_own.tgt_spd, i_value, 1'b1);
            LT_ASPEED: o_met = reach(i_own.act_spd, i_value, 1'b1);
            default:   o_met = 1'b0;
         endcase
      end
   end

endmodule

// ==== mss_sequencer.sv ====
`timescale 1ns/1ns
// Per-axis step sequencer
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int STEPS = 256     // Table depth in steps
)
(
   input  wire logic              i_clk,        // System clock
   input  wire logic              i_reset,      // Async reset, high
   input  wire logic              i_tick,       // 1 ms loop tick pulse
   input  wire logic              i_host_valid, // Host command strobe
   input  wire mss_cmd_t          i_host_cmd,   // Host command words
   input  wire logic              i_tbl_we,     // Table word write
   input  wire logic [7:0]        i_tbl_step,   // Step index to write
   input  wire logic [2:0]        i_tbl_word,   // Word within step
   input  wire logic [15:0]       i_tbl_data,   // Word value
   input  wire mss_axis_t         i_own,        // This axis feedback
   input  wire mss_axis_t         i_other,      // Other axis feedback
   output mss_cmd_t               o_cmd,        // Step command words
   output logic                   o_cmd_valid,  // Step command pulse
   output logic [7:0]             o_step,       // Current step
   output logic                   o_running,    // Sequence active
   output logic                   o_estop       // Emergency stop
);

   // ----------------------------------------
   // Storage and state
   // ----------------------------------------
   logic [15:0] table_q [STEPS*WORDS_STEP];  // Step table, eight words each
   mss_state_t  state_q;                     // Sequencer state
   logic [7:0]  step_q;                      // Current step index
   logic [7:0]  pend_q;                      // Step to enter next tick
   logic        pend_v_q;                    // Pending start
   logic [15:0] delay_q;                     // Elapsed ms in step
   mss_cmd_t    cmd_q;                       // Command out
   logic        cmd_v_q;                     // Command pulse
   logic        estop_q;                     // Emergency stop flag
   logic [7:0]  ltype;                       // Current advance code
   logic [7:0]  lnext;                       // Current successor
   logic [15:0] lval;                        // Current advance operand
   logic        met;                         // Condition holds
   logic        is_halt;                     // Host stop command
   logic        is_zap;                      // Quit or kill
   logic        is_trig;                     // Host trigger

   // Word address in table
   function automatic logic [10:0] waddr(input logic [7:0] s, input logic [2:0] w);
      waddr = {s, w};
   endfunction

   assign ltype   = table_q[waddr(step_q, W_LINK)][LNK_TYPE_HI:LNK_TYPE_LO]; // RULE16
   assign lnext   = table_q[waddr(step_q, W_LINK)][LNK_NEXT_HI:LNK_NEXT_LO];
   assign lval    = table_q[waddr(step_q, W_LVAL)];
   assign is_trig = i_host_valid && (i_host_cmd.cmd[7:0] == CMD_TRIGGER);    // RULE4
   assign is_zap  = i_host_valid && ((i_host_cmd.cmd[7:0] == CMD_QUIT) ||
                                     (i_host_cmd.cmd[7:0] == CMD_KILL));
   assign is_halt = i_host_valid && (i_host_cmd.cmd[7:0] == CMD_HALT);

   // ----------------------------------------
   // Condition evaluator
   // ----------------------------------------
   mss_link_eval u_eval (
      .i_type       (ltype),
      .i_value      (lval),
      .i_own        (i_own),
      .i_other      (i_other),
      .i_delay_done (delay_q >= lval),
      .o_met        (met)
   );

   // ----------------------------------------
   // Step table writes from host
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_tbl_we) begin
         table_q[waddr(i_tbl_step, i_tbl_word)] <= i_tbl_data;       // RULE14 RULE15
      end
   end

   // ----------------------------------------
   // Pending start from trigger
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pend_q   <= STEP_RST;
         pend_v_q <= 1'b0;
      end else if (is_trig) begin
         pend_q   <= i_host_cmd.oper[7:0];   // Only operand used  RULE5
         pend_v_q <= 1'b1;                                            // RULE19
      end else if (i_host_valid && (is_zap || is_halt)) begin
         pend_v_q <= 1'b0;                                            // RULE6
      end else if (i_tick && pend_v_q) begin
         pend_v_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sequencer state machine
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= ST_IDLE;
         step_q  <= STEP_RST;
      end else if (is_zap) begin
         state_q <= ST_IDLE;
         step_q  <= STEP_RST;                                         // RULE7
      end else if (is_halt) begin
         state_q <= ST_IDLE;                                          // RULE6
      end else if (i_tick && pend_v_q && !is_trig) begin
         step_q  <= pend_q;                                           // RULE4 RULE19
         state_q <= ST_ISSUE;
      end else begin
         unique case (state_q)
            ST_IDLE: state_q <= ST_IDLE;
            ST_ISSUE: state_q <= ST_TEST;                             // RULE1
            ST_TEST: begin
               if (ltype == LT_END) begin
                  state_q <= ST_IDLE;                                 // RULE10
               end else if (i_tick && met) begin
                  state_q <= ST_NEXT;                                 // RULE3
               end
            end
            ST_NEXT: begin
               if (i_tick) begin
                  step_q  <= lnext;                                   // RULE2
                  state_q <= ST_ISSUE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Millisecond delay counter
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         delay_q <= ZERO_W;
      end else if (state_q == ST_ISSUE) begin
         delay_q <= ZERO_W;
      end else if (state_q == ST_TEST && i_tick && delay_q != 16'hffff) begin
         delay_q <= delay_q + 16'h0001;                               // RULE13
      end
   end

   // ----------------------------------------
   // Command issue on step entry
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cmd_q   <= '0;
         cmd_v_q <= 1'b0;
      end else begin
         cmd_v_q <= 1'b0;
         if (state_q == ST_ISSUE && !is_zap && !is_halt) begin
            cmd_q.mode  <= table_q[waddr(step_q, W_MODE)];
            cmd_q.accel <= table_q[waddr(step_q, W_ACCEL)];
            cmd_q.decel <= table_q[waddr(step_q, W_DECEL)];
            cmd_q.speed <= table_q[waddr(step_q, W_SPEED)];
            cmd_q.oper  <= table_q[waddr(step_q, W_OPER)];
            cmd_q.cmd   <= table_q[waddr(step_q, W_CMD)];
            cmd_v_q     <= (table_q[waddr(step_q, W_CMD)] != ZERO_W); // RULE1 RULE12
         end
      end
   end

   // ----------------------------------------
   // Emergency stop latch
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         estop_q <= 1'b0;
      end else if (i_host_valid && i_host_cmd.cmd[7:0] == CMD_KILL) begin
         estop_q <= 1'b1;                                             // RULE8
      end else if (is_trig) begin
         estop_q <= 1'b0;    // New sequence clears stop
      end
   end

   assign o_cmd       = cmd_q;
   assign o_cmd_valid = cmd_v_q;
   assign o_step      = step_q;
   assign o_running   = (state_q != ST_IDLE) || pend_v_q;
   assign o_estop     = estop_q;

endmodule

// ==== mss_assertions.sv ====
`timescale 1ns/1ns
module mss_assertions
   import mss_pkg::*;
#(parameter int STEPS = 256)
(
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic       i_tick,
   input wire logic       i_host_valid,
   input wire mss_cmd_t   i_host_cmd,
   input wire logic       o_cmd_valid,
   input wire logic [7:0] o_step,
   input wire logic       o_running,
   input wire logic       o_estop
);
   // ----------------
   // Command decode
   // ----------------
   logic [7:0] hc;                 // Host character code
   logic       trg, hlt, kil, stp; // Trigger, halt, kill, quit or kill
   logic       pend_q;             // Trigger awaiting its tick
   logic [7:0] pstep_q;            // Its start step
   assign hc  = i_host_cmd.cmd[7:0];
   assign trg = i_host_valid && hc == CMD_TRIGGER;
   assign hlt = i_host_valid && hc == CMD_HALT;
   assign kil = i_host_valid && hc == CMD_KILL;
   assign stp = kil || (i_host_valid && hc == CMD_QUIT);
   // Holds a trigger until the tick that starts it or a halt, quit or kill
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pend_q  <= 1'b0;
         pstep_q <= STEP_RST;
      end else if (trg) begin
         pend_q  <= 1'b1;
         pstep_q <= i_host_cmd.oper[7:0];
      end else if (i_tick || hlt || stp) begin
         pend_q <= 1'b0;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   a_trig_runs: assert property (trg |=> o_running) else $error("trigger ignored");
   a_trig_step: assert property (pend_q && i_tick && !i_host_valid |=> o_step == pstep_q)
      else $error("wrong start step");
   a_issue_late: assert property (o_cmd_valid |-> $past(i_tick, 2)) else $error("issue off tick");
   a_step_moves: assert property (!$stable(o_step) |-> $past(i_tick) || $past(stp))
      else $error("step moved off tick");
   a_halt_keep: assert property (hlt |=> $stable(o_step) && !o_running) else $error("halt failed");
   a_stop_zero: assert property (stp |=> o_step == STEP_RST && !o_running)
      else $error("stop failed");
   a_kill_estop: assert property (kil |=> o_estop) else $error("no estop");
   a_estop_hold: assert property (o_estop && !trg |=> o_estop) else $error("estop dropped");
   c_trig: cover property (trg);
   c_kill: cover property (kil);
   c_halt: cover property (hlt ##1 !o_running);
endmodule
bind mss_sequencer mss_assertions #(.STEPS(STEPS)) u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_tick(i_tick),
   .i_host_valid(i_host_valid), .i_host_cmd(i_host_cmd), .o_cmd_valid(o_cmd_valid), .o_step(o_step),
   .o_running(o_running), .o_estop(o_estop));

// ==== mss_host_model.sv ====
`timescale 1ns/1ns
// Host controller stand-in: commands and table writes
module mss_host_model
   import mss_pkg::*;
(
   input  wire logic   i_clk,
   output logic        o_valid,
   output mss_cmd_t    o_cmd,
   output logic        o_we,
   output logic [7:0]  o_step,
   output logic [2:0]  o_word,
   output logic [15:0] o_data
);
   initial {o_valid, o_cmd, o_we, o_step, o_word, o_data} = '0;
   // One-cycle command, spare words carry junk
   task automatic send(input logic [7:0] c, input logic [15:0] op, input logic [63:0] jk);
      @(negedge i_clk);
      o_cmd   <= {jk, op, 8'h00, c};
      o_valid <= 1'b1;
      @(negedge i_clk);
      o_valid <= 1'b0;
      o_cmd   <= ~o_cmd; // Stale bus, never a copy
   endtask
   // Whole step, words in stored order
   task automatic wstep(input logic [7:0] s, input logic [15:0] cm, input logic [15:0] op,
                        input logic [7:0] nx, input logic [7:0] lt, input logic [15:0] lv);
      logic [15:0] w [8];
      w = '{16'h0001, 16'h0064, 16'h0064, 16'h2710, op, cm, {nx, lt}, lv};
      for (int i = 0; i < 8; i++) begin
         @(negedge i_clk);
         o_we   <= 1'b1;
         o_step <= s;
         o_word <= 3'(i);
         o_data <= w[i];
      end
      @(negedge i_clk);
      o_we   <= 1'b0;
      o_data <= ~o_data;
   endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   import mss_pkg::*;
   localparam logic [15:0] GO = 16'h0047; // Move command
   logic        clk = 1'b0, reset = 1'b1, tick = 1'b0, hv, we, ocv, orun, oest, got;
   logic [2:0]  tcnt = 3'h0, tw;
   logic [7:0]  ts, ostep;
   logic [7:0]  sc [3] = '{CMD_HALT, CMD_QUIT, CMD_KILL}; // Stop codes
   logic [15:0] td, stat = 16'h0000;
   mss_cmd_t    hcmd, ocmd;
   mss_axis_t   own = '0, oth = '0;
   int          num_errors = 0, checked = 0, cyc = 0, ncv = 0, n0, n;
   integer      seed = 32'hcaaa4032;
   always #20 clk = ~clk;
   // Eight-clock tick, random feedback except own status, which follows stat
   always @(negedge clk) begin
      tcnt <= tcnt + 3'h1;
      tick <= (tcnt == 3'h7);
      own  <= {64'({$random(seed), $random(seed)}), stat};
      oth  <= 80'({$random(seed), $random(seed), $random(seed)});
   end
   // Issue pulse count, hang limit
   always @(posedge clk) begin
      ncv = ncv + ((ocv === 1'b1) ? 1 : 0);
      cyc = cyc + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         stop_test();
      end
   end
   mss_host_model hm (.i_clk(clk), .o_valid(hv), .o_cmd(hcmd), .o_we(we), .o_step(ts), .o_word(tw), .o_data(td));
   mss_sequencer #(.STEPS(256)) dut (.i_clk(clk), .i_reset(reset), .i_tick(tick), .i_host_valid(hv),
      .i_host_cmd(hcmd), .i_tbl_we(we), .i_tbl_step(ts), .i_tbl_word(tw), .i_tbl_data(td), .i_own(own),
      .i_other(oth), .o_cmd(ocmd), .o_cmd_valid(ocv), .o_step(ostep), .o_running(orun), .o_estop(oest));
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("FAIL %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // Wait k ticks, then let updates land
   task automatic tk(input int k);
      repeat (k) do @(posedge clk); while (tick !== 1'b1);
      @(negedge clk);
   endtask
   // Start a chain and wait for its issue
   task automatic trig(input logic [7:0] s);
      stat = ZERO_W;
      hm.send(CMD_TRIGGER, {8'h00, s}, {$random(seed), $random(seed)});
      got = 1'b0;
      for (int i = 0; i < 40 && !got; i++) begin
         @(negedge clk);
         got = (ocv === 1'b1);
      end
      chk(16'(got), 16'h0001);
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Step shown after a stop command
   function automatic logic [7:0] stop_step(input logic [7:0] c, input logic [7:0] cur);
      stop_step = (c == CMD_HALT) ? cur : STEP_RST;
   endfunction
   // Enhanced advance code from its fields
   function automatic logic [7:0] enh_code(input logic [1:0] ax, input logic gt, input logic [2:0] par);
      enh_code = {1'b1, ax, gt, 1'b0, par};
   endfunction
   initial begin
      repeat (6) @(negedge clk);
      reset = 1'b0;
      // Move, wait, move and end
      hm.wstep(8'h0f, GO, 16'd15500, 8'h10, LT_BSET, 16'h0001);
      hm.wstep(8'h10, ZERO_W, 16'd10000, 8'h11, LT_DELAY, 16'h0005);
      hm.wstep(8'h11, GO, 16'd3000, STEP_RST, LT_END, ZERO_W);
      trig(8'h0f);
      chk(ocmd.oper, 16'd15500);
      chk(ocmd.cmd, GO);
      chk(ocmd.speed, 16'h2710);
      tk(3);
      chk(16'(ostep), 16'h000f);
      stat = 16'h0001;
      tk(1);
      chk(16'(ostep), 16'h000f);
      tk(1);
      chk(16'(ostep), 16'h0010);
      n0 = ncv;
      for (n = 0; ostep === 8'h10 && n < 20; n++) tk(1);
      chk(16'(n >= 5 && n <= 7), 16'h0001);
      chk(16'(ncv - n0), 16'h0000);
      tk(1);
      chk(16'(orun), 16'h0000);
      // Step 16 now moves, so a missed stop shows a pulse
      hm.wstep(8'h10, GO, 16'd10000, 8'h11, LT_DELAY, 16'h0005);
      // Halt, quit and kill on a waiting step
      foreach (sc[i]) begin
         trig(8'h0f);
         hm.send(sc[i], 16'($random(seed)), {$random(seed), $random(seed)});
         n0 = ncv;
         stat = 16'h0001;
         tk(3);
         chk(16'(orun), 16'h0000);
         chk(16'(ncv - n0), 16'h0000);
         chk(16'(ostep), 16'(stop_step(sc[i], 8'h0f)));
         chk(16'(oest), 16'(i == 2));
      end
      // Second trigger abandons the waiting step
      trig(8'h0f);
      hm.send(CMD_TRIGGER, 16'h0011, {$random(seed), $random(seed)});
      tk(1);
      chk(16'(ostep), 16'h0011);
      repeat (3) @(negedge clk);
      chk(ocmd.oper, 16'd3000);
      // Enhanced status code, any selected bit
      hm.wstep(8'h20, GO, 16'h2222, 8'h11, enh_code(2'b00, 1'b1, PAR_STATUS), 16'h0006);
      trig(8'h20);
      tk(1);
      chk(16'(ostep), 16'h0020);
      stat = 16'h0004;
      tk(2);
      chk(16'(ostep), 16'h0011);
      stop_test();
   end
endmodule
